/* File: hdl/ccm_defs.svh */
// constants of the converter current monitor
`ifndef CCM_DEFS_SVH
`define CCM_DEFS_SVH

// control clock and scan step
`define CCM_CLK_NS          40
`define CCM_MS_NS           1000000
`define CCM_SCAN_NS         1000000
`define CCM_SCAN_CYC        (`CCM_SCAN_NS / `CCM_CLK_NS)

// converter load integrator, currents in units of 0.1 A
`define CCM_CONV_IMAX       16'h0080
`define CCM_CONV_TMAX_MS    1000
`define CCM_CONV_TMAX_STEPS (`CCM_CONV_TMAX_MS * `CCM_MS_NS / `CCM_SCAN_NS)

// rms over-current check
`define CCM_RMS_LEVEL       16'h00C8
`define CCM_RMS_QUAL_MS     100
`define CCM_RMS_QUAL_STEPS  (`CCM_RMS_QUAL_MS * `CCM_MS_NS / `CCM_SCAN_NS)

// dc-link thresholds in volts
`define CCM_UDC_UV_V        12'h01C2
`define CCM_UDC_BRAKE_V     12'h02EE
`define CCM_UDC_OV_V        12'h0320

`endif

/* File: hdl/ccm_i2t.sv */
// load integrator: accumulates squared current above the continuous level
`timescale 1ns/1ps
module ccm_i2t #(
  parameter int IW = 16,
  parameter int TW = 16
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // control
  input  wire logic          step,
  input  wire logic          clr,
  // settings and measurement
  input  wire logic [IW-1:0] i_cont,
  input  wire logic [IW-1:0] i_max,
  input  wire logic [TW-1:0] t_max_steps,
  input  wire logic [IW-1:0] i_eff,
  // result
  output logic               trip_r
);
  localparam int SQ = 2 * IW;
  localparam int LW = SQ + TW;
  localparam int AW = LW + 2;

  logic signed [AW-1:0] acc_r;

  wire [SQ-1:0]        ieff2 = i_eff * i_eff;
  wire [SQ-1:0]        icont2 = i_cont * i_cont;
  wire [SQ-1:0]        imax2 = i_max * i_max;
  wire [SQ-1:0]        span = (imax2 > icont2) ? imax2 - icont2 : '0;
  wire [LW-1:0]        lim = span * t_max_steps;
  wire signed [AW-1:0] delta = $signed(AW'(ieff2)) - $signed(AW'(icont2));
  wire signed [AW-1:0] sum = acc_r + delta;
  wire signed [AW-1:0] acc_nxt = sum[AW-1] ? '0 : sum;
  wire                 over = acc_r > $signed(AW'(lim));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r  <= '0;
      trip_r <= 1'b0;
    end else begin
      if (clr) begin
        acc_r <= '0;
      end else if (step) begin
        acc_r <= acc_nxt;
      end
      // a clear drops the trip at its own edge, but the stale trip still relatches a fault during that clear cycle
      trip_r <= over & ~clr;
    end
  end

  property p_i2t_accum;
    @(posedge ref_clk) disable iff (!rst_n)
      (step && !clr && !sum[AW-1]) |=> (acc_r == $past(sum));
  endproperty
  a_i2t_accum: assert property (p_i2t_accum) else $error("integrator missed a step");

  property p_i2t_strict;
    @(posedge ref_clk) disable iff (!rst_n)
      (acc_r == $signed(AW'(lim))) |=> !trip_r;
  endproperty
  a_i2t_strict: assert property (p_i2t_strict) else $error("trip at limit reached");

  property p_i2t_clr;
    @(posedge ref_clk) disable iff (!rst_n)
      clr |=> !trip_r;
  endproperty
  a_i2t_clr: assert property (p_i2t_clr) else $error("trip left after clear");
endmodule // ccm_i2t

/* File: hdl/ccm_monitor.sv */
// converter current monitor: short-circuit, dc-link, load integral and rms protection
// How it works
// - the three motor phases and the brake resistor path are watched for short circuit.
// - a short circuit turns off pwm and the brake resistor with no software in the path.
// - after a short circuit the mechanical brake engages and the short-circuit fault shows.
// - short-circuit detection has no settings at all.
// - below the undervoltage level pwm turns off and the brake engages at once.
// - each integrator limit is (imax squared minus icont squared) times the allowed time.
// - each scan step adds (ieff squared minus icont squared) times one step to the sum.
// - an integrator trips only when its sum is strictly above its limit.
// - motor and converter integrators are separate instances with their own settings.
// - the motor integrator uses nominal current, maximum current and allowed time.
// - a motor integrator trip shows the motor overload fault and asks a ramp stop.
// - the converter integrator uses the power-class current, 12.8 A and 1 s.
// - a converter integrator trip shows the converter overload fault and a ramp stop.
// - rms current above 20 A for 100 ms shows the rms fault and asks a ramp stop.
// - dc-link at the braking level switches the brake resistor on in the run and ramp states only, so not above the overvoltage level.
// - dc-link above the overvoltage level shuts down with a fault.
`timescale 1ns/1ps
`include "ccm_defs.svh"
module ccm_monitor #(
  parameter int          SCAN_CYC  = `CCM_SCAN_CYC,
  parameter logic [11:0] UDC_BRAKE = `CCM_UDC_BRAKE_V,
  parameter logic [11:0] UDC_OV    = `CCM_UDC_OV_V
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // sensing
  input  wire ccm_pkg::ccm_sc_t        sc_det,
  input  wire ccm_pkg::ccm_meas_t      meas,
  // settings and control
  input  wire ccm_pkg::ccm_motor_cfg_t motor_cfg,
  input  wire logic [15:0]             conv_class_i,
  input  wire logic                    fault_reset,
  // power stage and drive
  output logic                         pwm_en_r,
  output logic                         brake_res_on_r,
  output logic                         mech_brake_r,
  output logic                         ramp_stop_r,
  // status
  output ccm_pkg::ccm_fault_t          faults_r,
  output ccm_pkg::ccm_state_t          state_r
);
  // ****************************************
  // scan step and integrators
  // ****************************************
  logic tick;
  logic mot_trip;
  logic conv_trip;

  ccm_scan_tick #(
    .SCAN_CYC (SCAN_CYC)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick_r  (tick)
  );

  // motor integrator
  ccm_i2t #(
    .IW (16),
    .TW (16)
  ) u_mot_i2t (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .step        (tick),
    .clr         (fault_reset),
    .i_cont      (motor_cfg.i_nom),
    .i_max       (motor_cfg.i_max),
    .t_max_steps (motor_cfg.overcurrent_allow_time),
    .i_eff       (meas.motor_irms),
    .trip_r      (mot_trip)
  );

  // converter integrator
  ccm_i2t #(
    .IW (16),
    .TW (16)
  ) u_conv_i2t (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .step        (tick),
    .clr         (fault_reset),
    .i_cont      (conv_class_i),
    .i_max       (`CCM_CONV_IMAX),
    .t_max_steps (16'(`CCM_CONV_TMAX_STEPS)),
    .i_eff       (meas.conv_irms),
    .trip_r      (conv_trip)
  );

  // ****************************************
  // detection
  // ****************************************
  // fixed short-circuit detection, nothing to configure
  wire sc_any = sc_det.u | sc_det.v | sc_det.w | sc_det.brk;
  wire uv = meas.udc < `CCM_UDC_UV_V;
  wire ov = meas.udc > UDC_OV;
  wire brake_zone = meas.udc >= UDC_BRAKE;
  wire rms_hi = meas.conv_irms > `CCM_RMS_LEVEL;

  // ****************************************
  // rms qualification
  // ****************************************
  localparam logic [7:0] QUAL_LAST = 8'(`CCM_RMS_QUAL_STEPS - 1);
  logic [7:0] rms_cnt_r;
  wire        rms_trip = tick & rms_hi & (rms_cnt_r == QUAL_LAST);
  wire [7:0]  rms_cnt_nxt = !rms_hi ? 8'h00 :
                            (rms_cnt_r == QUAL_LAST) ? rms_cnt_r : rms_cnt_r + 8'h01;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rms_cnt_r <= 8'h00;
    end else if (tick) begin
      rms_cnt_r <= rms_cnt_nxt;
    end
  end

  // ****************************************
  // fault latches
  // ****************************************
  // a new event in the reset cycle wins over the reset
  wire keep = ~fault_reset;
  ccm_pkg::ccm_fault_t faults_nxt;
  assign faults_nxt.short_circuit_fault = sc_any | (faults_r.short_circuit_fault & keep);
  assign faults_nxt.motor_overload_fault = mot_trip | (faults_r.motor_overload_fault & keep);
  assign faults_nxt.converter_overload_fault =
    conv_trip | (faults_r.converter_overload_fault & keep);
  assign faults_nxt.rms_overcurrent_fault = rms_trip | (faults_r.rms_overcurrent_fault & keep);
  assign faults_nxt.overvoltage_fault = ov | (faults_r.overvoltage_fault & keep);
  assign faults_nxt.undervoltage = uv;

  // ****************************************
  // drive state
  // ****************************************
  wire hard_off = faults_nxt.short_circuit_fault | faults_nxt.overvoltage_fault | uv;
  wire ramp_req = faults_nxt.motor_overload_fault | faults_nxt.converter_overload_fault |
                  faults_nxt.rms_overcurrent_fault;
  wire ccm_pkg::ccm_state_t state_nxt = hard_off ? ccm_pkg::CCM_OFF :
                                       ramp_req ? ccm_pkg::CCM_RAMP : ccm_pkg::CCM_RUN;

  logic pwm_en_nxt;
  logic mech_brake_nxt;
  logic brake_res_nxt;

  always_comb begin
    case (state_nxt)
      ccm_pkg::CCM_RUN: begin
        pwm_en_nxt     = 1'b1;
        mech_brake_nxt = 1'b0;
        brake_res_nxt  = brake_zone;
      end
      ccm_pkg::CCM_RAMP: begin
        pwm_en_nxt     = 1'b1;
        mech_brake_nxt = 1'b0;
        brake_res_nxt  = brake_zone;
      end
      ccm_pkg::CCM_OFF: begin
        pwm_en_nxt     = 1'b0;
        mech_brake_nxt = 1'b1;
        brake_res_nxt  = 1'b0;
      end
      default: begin
        pwm_en_nxt     = 1'b0;
        mech_brake_nxt = 1'b1;
        brake_res_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      faults_r       <= '0;
      state_r        <= ccm_pkg::CCM_OFF;
      pwm_en_r       <= 1'b0;
      mech_brake_r   <= 1'b1;
      brake_res_on_r <= 1'b0;
      ramp_stop_r    <= 1'b0;
    end else begin
      faults_r       <= faults_nxt;
      state_r        <= state_nxt;
      pwm_en_r       <= pwm_en_nxt;
      mech_brake_r   <= mech_brake_nxt;
      brake_res_on_r <= brake_res_nxt;
      ramp_stop_r    <= ramp_req;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_hard_off;
    !pwm_en_r && mech_brake_r && !brake_res_on_r;
  endsequence

  sequence s_ramping;
    ramp_stop_r && pwm_en_r;
  endsequence

  property p_sc_kill;
    sc_any |=> s_hard_off;
  endproperty
  a_sc_kill: assert property (p_sc_kill) else $error("short circuit left pwm on");

  property p_sc_code;
    sc_any |=> faults_r.short_circuit_fault ##1 (faults_r.short_circuit_fault || $past(fault_reset));
  endproperty
  a_sc_code: assert property (p_sc_code) else $error("short-circuit fault not shown");

  property p_uv_off;
    uv |=> s_hard_off ##0 faults_r.undervoltage;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("undervoltage did not shut down");

  property p_latch;
    (faults_r.short_circuit_fault && !fault_reset)[*2] |=> faults_r.short_circuit_fault;
  endproperty
  a_latch: assert property (p_latch) else $error("fault dropped without reset");

  property p_motor_trip;
    (mot_trip && !hard_off) |=> faults_r.motor_overload_fault ##0 s_ramping;
  endproperty
  a_motor_trip: assert property (p_motor_trip) else $error("motor overload not acted on");

  property p_conv_trip;
    (conv_trip && !hard_off) |=> faults_r.converter_overload_fault ##0 s_ramping;
  endproperty
  a_conv_trip: assert property (p_conv_trip) else $error("converter overload not acted on");

  property p_rms_early;
    (tick && rms_hi && rms_cnt_r < QUAL_LAST && !faults_r.rms_overcurrent_fault)
      |=> !faults_r.rms_overcurrent_fault;
  endproperty
  a_rms_early: assert property (p_rms_early) else $error("rms fault before qualification");

  property p_rms_trip;
    rms_trip |=> faults_r.rms_overcurrent_fault && ramp_stop_r;
  endproperty
  a_rms_trip: assert property (p_rms_trip) else $error("rms fault missing");

  property p_brake_res;
    (brake_zone && !hard_off) |=> brake_res_on_r;
  endproperty
  a_brake_res: assert property (p_brake_res) else $error("brake resistor not switched on");

  property p_ov_off;
    ov |=> faults_r.overvoltage_fault ##0 s_hard_off;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("overvoltage did not shut down");

  property p_sc_over_clr;
    (sc_any && fault_reset) |=> faults_r.short_circuit_fault;
  endproperty
  a_sc_over_clr: assert property (p_sc_over_clr) else $error("reset beat short circuit");

  property p_ov_latch;
    (faults_r.overvoltage_fault && !fault_reset) |=> faults_r.overvoltage_fault;
  endproperty
  a_ov_latch: assert property (p_ov_latch) else $error("overvoltage fault dropped");

  property p_mot_latch;
    (faults_r.motor_overload_fault && !fault_reset) |=> faults_r.motor_overload_fault;
  endproperty
  a_mot_latch: assert property (p_mot_latch) else $error("motor fault dropped");

  property p_conv_latch;
    (faults_r.converter_overload_fault && !fault_reset) |=> faults_r.converter_overload_fault;
  endproperty
  a_conv_latch: assert property (p_conv_latch) else $error("converter fault dropped");

  property p_rms_latch;
    (faults_r.rms_overcurrent_fault && !fault_reset) |=> faults_r.rms_overcurrent_fault;
  endproperty
  a_rms_latch: assert property (p_rms_latch) else $error("rms fault dropped");

  property p_uv_follow;
    !uv |=> !faults_r.undervoltage;
  endproperty
  a_uv_follow: assert property (p_uv_follow) else $error("undervoltage flag stuck");

  property p_brake_res_off;
    !brake_zone |=> !brake_res_on_r;
  endproperty
  a_brake_res_off: assert property (p_brake_res_off) else $error("resistor stuck on");

  property p_off_outputs;
    (state_r == ccm_pkg::CCM_OFF) |-> s_hard_off;
  endproperty
  a_off_outputs: assert property (p_off_outputs) else $error("off state with pwm enabled");

  property p_ramp_outputs;
    (state_r == ccm_pkg::CCM_RAMP) |-> s_ramping ##0 !mech_brake_r;
  endproperty
  a_ramp_outputs: assert property (p_ramp_outputs) else $error("ramp stop not driven");

  property p_run_clean;
    (state_r == ccm_pkg::CCM_RUN) |-> (faults_r == '0) && pwm_en_r && !mech_brake_r;
  endproperty
  a_run_clean: assert property (p_run_clean) else $error("running with a fault set");

  property p_rms_restart;
    (tick && !rms_hi) |=> (rms_cnt_r == 8'h00);
  endproperty
  a_rms_restart: assert property (p_rms_restart) else $error("rms count not restarted");

endmodule // ccm_monitor

/* File: hdl/ccm_pkg.sv */
// types of the converter current monitor
package ccm_pkg;

  typedef struct packed {
    logic brk;
    logic w;
    logic v;
    logic u;
  } ccm_sc_t;

  typedef struct packed {
    logic [15:0] motor_irms;
    logic [15:0] conv_irms;
    logic [11:0] udc;
  } ccm_meas_t;

  typedef struct packed {
    logic [15:0] i_nom;
    logic [15:0] i_max;
    logic [15:0] overcurrent_allow_time;
  } ccm_motor_cfg_t;

  typedef struct packed {
    logic short_circuit_fault;
    logic motor_overload_fault;
    logic converter_overload_fault;
    logic rms_overcurrent_fault;
    logic overvoltage_fault;
    logic undervoltage;
  } ccm_fault_t;

  typedef enum logic [1:0] {
    CCM_RUN  = 2'b00,
    CCM_RAMP = 2'b01,
    CCM_OFF  = 2'b10
  } ccm_state_t;

endpackage

/* File: hdl/ccm_scan_tick.sv */
// scan step divider: one-cycle enable every SCAN_CYC clocks
`timescale 1ns/1ps
module ccm_scan_tick #(
  parameter int SCAN_CYC = 25000
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // scan enable
  output logic      tick_r
);
  logic [15:0] cnt_r;
  wire         last = (cnt_r == 16'(SCAN_CYC - 1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= last ? 16'h0000 : cnt_r + 16'h0001;
      tick_r <= last;
    end
  end
endmodule // ccm_scan_tick

/* File: test/ccm_stage_model.sv */
// far-side model: power stage current sensing and dc-link, commanded by the bench
`timescale 1ns/1ps
module ccm_stage_model (
  // bench commands
  input  wire logic [3:0]     sc_cmd,
  input  wire logic [15:0]    mot_i,
  input  wire logic [15:0]    conv_i,
  input  wire logic [11:0]    udc_v,
  // bridge state seen back
  input  wire logic           pwm_en_r,
  // sensing towards the monitor
  output ccm_pkg::ccm_sc_t    sc_det,
  output ccm_pkg::ccm_meas_t  meas
);
  // ****************************************
  // sensing
  // ****************************************
  assign sc_det = ccm_pkg::ccm_sc_t'(sc_cmd);
  // no current flows while the bridge is blocked
  assign meas = {pwm_en_r ? mot_i : 16'h0000, pwm_en_r ? conv_i : 16'h0000, udc_v};
endmodule // ccm_stage_model

/* File: test/tb.sv */
// self-checking bench of the converter current monitor
`timescale 1ns/1ps
module tb;
  localparam int SC = 8;
  logic                    ref_clk      = 1'b0;
  logic                    rst_n        = 1'b0;
  logic [3:0]              sc_cmd       = 4'h0;
  logic [15:0]             mot_i        = 16'h0000;
  logic [15:0]             conv_i       = 16'h0000;
  logic [11:0]             udc_v        = 12'h0258;
  logic [15:0]             conv_class_i = 16'h007F;
  logic                    fault_reset  = 1'b0;
  ccm_pkg::ccm_motor_cfg_t motor_cfg    = {16'h0032, 16'h0064, 16'h0001};
  ccm_pkg::ccm_sc_t        sc_det;
  ccm_pkg::ccm_meas_t      meas;
  logic                    pwm_en_r;
  logic                    brake_res_on_r;
  logic                    mech_brake_r;
  logic                    ramp_stop_r;
  ccm_pkg::ccm_fault_t     faults_r;
  ccm_pkg::ccm_state_t     state_r;
  int                      err_count    = 0;
  int                      tests_run    = 0;
  int                      cyc          = 0;
  logic [23:0]             exp_q[$];
  event                    chk;
  wire  [11:0]             outs;

  assign outs = {pwm_en_r, brake_res_on_r, mech_brake_r, ramp_stop_r, faults_r, state_r};

  ccm_stage_model ccm_stage_model_i (
    .sc_cmd   (sc_cmd),
    .mot_i    (mot_i),
    .conv_i   (conv_i),
    .udc_v    (udc_v),
    .pwm_en_r (pwm_en_r),
    .sc_det   (sc_det),
    .meas     (meas)
  );

  ccm_monitor #(.SCAN_CYC(SC)) ccm_monitor_i (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .sc_det         (sc_det),
    .meas           (meas),
    .motor_cfg      (motor_cfg),
    .conv_class_i   (conv_class_i),
    .fault_reset    (fault_reset),
    .pwm_en_r       (pwm_en_r),
    .brake_res_on_r (brake_res_on_r),
    .mech_brake_r   (mech_brake_r),
    .ramp_stop_r    (ramp_stop_r),
    .faults_r       (faults_r),
    .state_r        (state_r)
  );

  // ****************************************
  // clock, scan phase, helpers
  // ****************************************
  always #20 ref_clk = ~ref_clk;

  // counts edges since release so the bench knows where scan ticks fall
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // stops just after a tick was used: the next one is taken SC edges later
  task automatic align();
    @(negedge ref_clk);
    while (cyc % SC != 1) @(negedge ref_clk);
  endtask

  task automatic expect_out(input logic [11:0] e, input logic [11:0] m);
    exp_q.push_back({e, m});
    ->chk;
  endtask

  task automatic cmp_out(input logic [11:0] act, input logic [11:0] exp);
    tests_run++;
    if (act !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  always @(chk) begin : mon
    logic [23:0] n;
    n = exp_q.pop_front();
    cmp_out(outs & n[11:0], n[23:12] & n[11:0]);
  end

  // random quiet operating point, then two fault reset cycles: sums first, then faults
  task automatic clr();
    mot_i = 16'($urandom_range(50, 0));
    conv_i = 16'($urandom_range(127, 0));
    udc_v = 12'($urandom_range(749, 450));
    fault_reset = 1'b1;
    step(2);
    fault_reset = 1'b0;
    expect_out(12'h800, 12'hFFF);
  endtask

  task automatic print_verdict();
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    err_count++;
    print_verdict();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(55428));
    step(1);
    expect_out(12'h202, 12'hFFF);
    step(2);
    rst_n = 1'b1;
    step(1);
    expect_out(12'h800, 12'hFFF);
    for (int i = 0; i < 4; i++) begin
      sc_cmd = 4'(1 << i);
      step(1);
      expect_out(12'h282, 12'hFFF);
      sc_cmd = 4'h0;
      step(1);
      expect_out(12'h282, 12'hFFF);
      clr();
    end
    sc_cmd = 4'h2;
    fault_reset = 1'b1;
    step(1);
    expect_out(12'h282, 12'hFFF);
    sc_cmd = 4'h0;
    fault_reset = 1'b0;
    step(1);
    clr();
    udc_v = 12'h01C1;
    step(1);
    expect_out(12'h206, 12'hFFF);
    udc_v = 12'h01C2;
    step(1);
    expect_out(12'h800, 12'hFFF);
    udc_v = 12'h02ED;
    step(1);
    expect_out(12'h800, 12'hFFF);
    udc_v = 12'h02EE;
    step(1);
    expect_out(12'hC00, 12'hFFF);
    udc_v = 12'h0320;
    step(1);
    expect_out(12'hC00, 12'hFFF);
    udc_v = 12'h0321;
    step(1);
    expect_out(12'h20A, 12'hBFF);
    udc_v = 12'h0258;
    step(2);
    expect_out(12'h20A, 12'hFFF);
    clr();
    align();
    mot_i = 16'h0064;
    step(8);
    mot_i = 16'h0032;
    step(16);
    expect_out(12'h800, 12'hFFF);
    mot_i = 16'h0033;
    step(9);
    expect_out(12'h800, 12'hFFF);
    step(2);
    expect_out(12'h941, 12'hFFF);
    clr();
    align();
    conv_i = 16'h0080;
    step(8001);
    expect_out(12'h800, 12'hFFF);
    step(9);
    expect_out(12'h921, 12'hFFF);
    clr();
    conv_i = 16'h00C8;
    step(8 * 105);
    expect_out(12'h000, 12'h010);
    align();
    conv_i = 16'h00C9;
    step(795);
    expect_out(12'h000, 12'h010);
    step(8);
    expect_out(12'h911, 12'hFDF);
    clr();
    step(1);
    print_verdict();
  end
endmodule // tb
